// ===== common/dtt_cfg.svh
// register map, reset values and timing counts of the discrete input trip timer
`ifndef DTT_CFG_SVH
`define DTT_CFG_SVH
`define DTT_NUM_INST      6
`define DTT_NUM_FUNC      3
`define DTT_NUM_VAR       3
`define DTT_CLK_NS        100
`define DTT_TICK_NS       1000000
`define DTT_TICK_CYCLES   (`DTT_TICK_NS / `DTT_CLK_NS)
`define DTT_MS_PER_UNIT   10
`define DTT_ADDR_W        8
`define DTT_OFF_CTRL      8'h00
`define DTT_OFF_MODE      8'h04
`define DTT_OFF_TDLY0     8'h08
`define DTT_OFF_TIM0      8'h14
`define DTT_OFF_BLK       8'h20
`define DTT_OFF_STAT      8'h24
`define DTT_OFF_IRQS      8'h28
`define DTT_OFF_IRQM      8'h2c
`define DTT_OFF_ROUTE     8'h30
`define DTT_OFF_CNT0      8'h40
`define DTT_OFF_LAST      8'h54
`define DTT_CTRL_GRP_BIT  4
`define DTT_MODE_GRP1_LSB 4
`define DTT_TDLY_GRP1_LSB 16
`define DTT_TIM_DO_LSB    16
`define DTT_STAT_TRIP_LSB 8
`define DTT_RST_CTRL      32'h0000_0000
`define DTT_RST_MODE      32'h0000_0000
`define DTT_RST_TDLY      32'h0064_0064
`define DTT_RST_TIM       32'h0014_0005
`define DTT_RST_ROUTE     32'h0000_0000
`define DTT_RESP_OKAY     2'b00
`define DTT_RESP_SLVERR   2'b10
`endif

// ===== common/dtt_pkg.sv
// types shared by the discrete input trip timer files
package dtt_pkg;
    typedef enum logic [1:0] {
        DTT_IDLE,
        DTT_FILT,
        DTT_PICK,
        DTT_HOLD
    } dtt_state_t;

    typedef struct packed {
        logic [9:0]  pu_ms;
        logic [18:0] trip_ms;
        logic [15:0] do_ms;
    } dtt_chan_cfg_t;

    typedef struct packed {
        logic pickup;
        logic trip;
    } dtt_chan_out_t;
endpackage

// ===== design/dtt_channel.sv
// one protection instance: pickup filter, trip delay and drop-out hold
`timescale 1ns/100ps
module dtt_channel (
    // clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // timing and qualifiers
    input  wire logic                   tick,
    input  wire logic                   arm,
    input  wire logic                   blk,
    input  wire logic                   trig,
    input  wire dtt_pkg::dtt_chan_cfg_t cfg,
    // result
    output dtt_pkg::dtt_chan_out_t      res
);
    import dtt_pkg::*;

    dtt_state_t  state_q;
    logic [15:0] tmr_q;
    logic [18:0] trip_cnt_q;
    logic        trip_q;
    logic        pickup;

    assign pickup     = (state_q == DTT_PICK) || (state_q == DTT_HOLD);
    assign res.pickup = pickup;
    assign res.trip   = trip_q & pickup; // R13

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= DTT_IDLE;
            tmr_q   <= 16'h0000;
        end else if (!arm || blk) begin
            state_q <= DTT_IDLE; // R5 R9
            tmr_q   <= 16'h0000;
        end else begin
            case (state_q)
                DTT_IDLE: begin
                    tmr_q <= 16'h0000;
                    if (trig) begin
                        state_q <= (cfg.pu_ms == 10'h000) ? DTT_PICK : DTT_FILT;
                    end
                end
                DTT_FILT: begin
                    if (!trig) begin
                        state_q <= DTT_IDLE; // R7
                    end else if (tick) begin
                        tmr_q <= tmr_q + 16'h0001;
                        if (tmr_q + 16'h0001 >= {6'h00, cfg.pu_ms}) begin
                            state_q <= DTT_PICK; // R7
                        end
                    end
                end
                DTT_PICK: begin
                    tmr_q <= 16'h0000;
                    if (!trig) begin
                        state_q <= (cfg.do_ms == 16'h0000) ? DTT_IDLE : DTT_HOLD; // R8
                    end
                end
                DTT_HOLD: begin
                    if (trig) begin
                        state_q <= DTT_PICK;
                    end else if (tick) begin
                        tmr_q <= tmr_q + 16'h0001;
                        if (tmr_q + 16'h0001 >= cfg.do_ms) begin
                            state_q <= DTT_IDLE; // R8
                        end
                    end
                end
                default: begin
                    state_q <= DTT_IDLE;
                end
            endcase
        end
    end

    // trip timer runs only while pickup stays up without a break
    always_ff @(posedge aclk) begin
        if (!aresetn || !pickup) begin
            trip_cnt_q <= 19'h00000; // R13
            trip_q     <= 1'b0;
        end else begin
            if (tick && trip_cnt_q != 19'h7ffff) begin
                trip_cnt_q <= trip_cnt_q + 19'h00001;
            end
            if (trip_cnt_q >= cfg.trip_ms) begin
                trip_q <= 1'b1; // R6
            end
        end
    end

    sequence s_blocked;
        !arm || blk;
    endsequence

    AST_CH_SUPPRESS: assert property (@(posedge aclk) disable iff (!aresetn) // R5
        s_blocked |=> !res.pickup && !res.trip)
        else $error("pickup or trip while disarmed or blocked");

    AST_CH_TRIP_NEEDS_PICKUP: assert property (@(posedge aclk) disable iff (!aresetn) // R13
        $rose(res.trip) |-> $past(res.pickup))
        else $error("trip rose without pickup already held");

    AST_CH_PICKUP_FROM_TRIG: assert property (@(posedge aclk) disable iff (!aresetn) // R7
        $rose(res.pickup) |-> $past(trig) && $past(arm) && !$past(blk))
        else $error("pickup rose without a qualified trigger");

    AST_CH_ZERO_TRIP: assert property (@(posedge aclk) disable iff (!aresetn) // R6
        res.pickup && cfg.trip_ms == 19'h00000 && arm && !blk && trig
        ##1 res.pickup |-> res.trip)
        else $error("zero trip delay did not trip at once");
endmodule

// ===== design/dtt_sync.sv
// two-flop synchroniser for the digital trip inputs
`timescale 1ns/100ps
module dtt_sync (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // pins and synchronised levels
    input  wire logic [5:0]  din,
    output logic      [5:0]  dout
);
    logic [5:0] meta_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= 6'h00;
            dout   <= 6'h00;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule

// ===== design/dtt_top.sv
// discrete input trip timer: six instances, axi4-lite registers, counters, irq
// Overview of operation
// (R1) Oil-relay protection has two instances, pressure switch (0) and float switch (1).
// (R2) Each oil-relay instance is driven only by its own digital input, 1 and 2.
// (R3) Thermal-switch protection has trip-temperature (2) and alarm (3) instances, each on its input.
// (R4) Each external trip instance (4, 5) picks up from its own dedicated digital input.
// (R5) A function runs only with its global enable set and its active-group mode on.
// (R6) Trip follows pickup after a per-group trip delay of 0 to 300 s, default 1 s.
// (R7) The trigger must persist for a pickup delay of 0 to 1000 ms, default 5 ms.
// (R8) Pickup is held for a drop-out delay of 0 to 60 s, default 0.2 s, after the trigger ends.
// (R9) A selectable block source (none or a user variable) suppresses pickup per instance.
// (R10) Each instance counts pickup occurrences.
// (R11) Each instance counts trip occurrences.
// (R12) External trip can drive the breaker trip, a chosen relay or an indicator LED.
// (R13) Trip needs continuous pickup for the trip delay and clears together with pickup.
// (R14) Counters advance once per rising edge of pickup or trip.
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "dtt_cfg.svh"
module dtt_top #(
    parameter int TICK_CYCLES = `DTT_TICK_CYCLES
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // digital inputs and user variables
    input  wire logic [5:0]  trip_in,
    input  wire logic [2:0]  user_var,
    // protection outputs
    output logic [5:0]       pickup_o,
    output logic [5:0]       trip_o,
    output logic             cb_trip_o,
    output logic [3:0]       relay_o,
    output logic             led_o,
    output logic             irq_o
);
    import dtt_pkg::*;

    logic [31:0]    ctrl_q;
    logic [31:0]    mode_q;
    logic [31:0]    tdly_q [3];
    logic [31:0]    tim_q  [3];
    logic [31:0]    blk_q;
    logic [31:0]    irqm_q;
    logic [31:0]    route_q;
    logic [13:0]    irqs_q;
    logic [31:0]    cnt_q  [6];
    logic [5:0]     trip_sync;
    logic [13:0]    tick_cnt_q;
    logic           tick_q;
    logic           aw_hold_q;
    logic           w_hold_q;
    logic [7:0]     awaddr_q;
    logic [31:0]    wdata_q;
    logic [3:0]     wstrb_q;
    logic           commit;
    logic           rd_take;
    logic [31:0]    rd_d;
    logic           rd_ok;
    logic           grp;
    dtt_chan_out_t  chan [6];
    logic [5:0]     pu_now;
    logic [5:0]     tr_now;
    logic [13:0]    ev_set;

    assign commit  = aw_hold_q && w_hold_q && !bvalid;
    assign rd_take = arvalid && arready;
    assign grp     = ctrl_q[`DTT_CTRL_GRP_BIT];

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = dat[8*b +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a <= `DTT_OFF_ROUTE && a != 8'h34) ||
               (a >= `DTT_OFF_CNT0 && a <= `DTT_OFF_LAST);
    endfunction

    // millisecond tick shared by all timers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_q <= 14'h0000;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q == 14'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= 14'h0000;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 14'h0001;
            tick_q     <= 1'b0;
        end
    end

    dtt_sync u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (trip_in),
        .dout    (trip_sync)
    );

    generate
        for (genvar i = 0; i < `DTT_NUM_INST; i++) begin : g_inst
            localparam int F = i / 2;
            dtt_chan_cfg_t cfg;
            logic [1:0]    sel;
            logic          arm;
            logic          blk;
            logic [15:0]   tdly_units;

            assign tdly_units = grp ? tdly_q[F][31:`DTT_TDLY_GRP1_LSB] : tdly_q[F][15:0]; // R6
            assign cfg.pu_ms   = tim_q[F][9:0];
            assign cfg.trip_ms = 19'(tdly_units) * 19'(`DTT_MS_PER_UNIT);
            assign cfg.do_ms   = 16'(tim_q[F][28:`DTT_TIM_DO_LSB]) * 16'(`DTT_MS_PER_UNIT);
            assign arm = ctrl_q[F] && mode_q[grp ? `DTT_MODE_GRP1_LSB + F : F]; // R5
            assign sel = blk_q[2*i +: 2];
            assign blk = (sel != 2'b00) && user_var[sel - 2'b01]; // R9

            // each instance sees only its own input line
            dtt_channel u_chan (
                .aclk    (aclk),
                .aresetn (aresetn),
                .tick    (tick_q),
                .arm     (arm),
                .blk     (blk),
                .trig    (trip_sync[i]), // R1 R2 R3 R4
                .cfg     (cfg),
                .res     (chan[i])
            );

            assign pu_now[i] = chan[i].pickup;
            assign tr_now[i] = chan[i].trip;

            // pickup count low half, trip count high half; a write clears
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    cnt_q[i] <= 32'h0000_0000;
                end else begin
                    cnt_q[i][15:0] <= ((commit && awaddr_q == `DTT_OFF_CNT0 + 8'(4*i)) ?
                                       16'h0000 : cnt_q[i][15:0]) +
                                      16'(pu_now[i] && !pickup_o[i]); // R10 R14
                    cnt_q[i][31:16] <= ((commit && awaddr_q == `DTT_OFF_CNT0 + 8'(4*i)) ?
                                        16'h0000 : cnt_q[i][31:16]) +
                                       16'(tr_now[i] && !trip_o[i]); // R11 R14
                end
            end

            AST_CNT_ON_RISE: assert property (@(posedge aclk) disable iff (!aresetn) // R14
                pickup_o[i] && $past(pickup_o[i]) && !$past(commit) |->
                cnt_q[i][15:0] == $past(cnt_q[i][15:0]))
                else $error("pickup count moved while pickup was held");
        end
    endgenerate

    // registered outputs and routing of the external trip instances
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pickup_o  <= 6'h00;
            trip_o    <= 6'h00;
            cb_trip_o <= 1'b0;
            relay_o   <= 4'h0;
            led_o     <= 1'b0;
        end else begin
            pickup_o  <= pu_now;
            trip_o    <= tr_now;
            cb_trip_o <= (tr_now[4] && route_q[0]) || (tr_now[5] && route_q[8]); // R12
            led_o     <= (tr_now[4] && route_q[4]) || (tr_now[5] && route_q[12]); // R12
            for (int k = 0; k < 4; k++) begin
                relay_o[k] <= (tr_now[4] && route_q[1] && route_q[3:2] == 2'(k)) ||
                              (tr_now[5] && route_q[9] && route_q[11:10] == 2'(k)); // R12
            end
        end
    end

    // sticky event bits, read clears, a new event wins over the clear
    assign ev_set = {tr_now & ~trip_o, 2'b00, pu_now & ~pickup_o};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irqs_q <= 14'h0000;
            irq_o  <= 1'b0;
        end else begin
            irqs_q <= ((rd_take && araddr == `DTT_OFF_IRQS) ? 14'h0000 : irqs_q) | ev_set;
            irq_o  <= |(irqs_q & irqm_q[13:0]);
        end
    end

    // write address and data channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready   <= 1'b0;
            wready    <= 1'b0;
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= `DTT_RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awready   <= 1'b0;
                aw_hold_q <= 1'b1;
                awaddr_q  <= {awaddr[7:2], 2'b00};
            end else if (!aw_hold_q && !bvalid) begin
                awready <= 1'b1;
            end
            if (wvalid && wready) begin
                wready   <= 1'b0;
                w_hold_q <= 1'b1;
                wdata_q  <= wdata;
                wstrb_q  <= wstrb;
            end else if (!w_hold_q && !bvalid) begin
                wready <= 1'b1;
            end
            if (commit) begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                bvalid    <= 1'b1;
                bresp     <= mapped(awaddr_q) ? `DTT_RESP_OKAY : `DTT_RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // settings registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q  <= `DTT_RST_CTRL;
            mode_q  <= `DTT_RST_MODE;
            blk_q   <= 32'h0000_0000;
            irqm_q  <= 32'h0000_0000;
            route_q <= `DTT_RST_ROUTE;
            for (int f = 0; f < `DTT_NUM_FUNC; f++) begin
                tdly_q[f] <= `DTT_RST_TDLY;
                tim_q[f]  <= `DTT_RST_TIM;
            end
        end else if (commit) begin
            case (awaddr_q)
                `DTT_OFF_CTRL:  ctrl_q  <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h0000_0017;
                `DTT_OFF_MODE:  mode_q  <= merge(mode_q, wdata_q, wstrb_q) & 32'h0000_0077;
                `DTT_OFF_BLK:   blk_q   <= merge(blk_q, wdata_q, wstrb_q) & 32'h0000_0fff;
                `DTT_OFF_IRQM:  irqm_q  <= merge(irqm_q, wdata_q, wstrb_q) & 32'h0000_3f3f;
                `DTT_OFF_ROUTE: route_q <= merge(route_q, wdata_q, wstrb_q) & 32'h0000_1f1f;
                default: begin
                    for (int f = 0; f < `DTT_NUM_FUNC; f++) begin
                        if (awaddr_q == `DTT_OFF_TDLY0 + 8'(4*f)) begin
                            tdly_q[f] <= merge(tdly_q[f], wdata_q, wstrb_q);
                        end
                        if (awaddr_q == `DTT_OFF_TIM0 + 8'(4*f)) begin
                            tim_q[f] <= merge(tim_q[f], wdata_q, wstrb_q) & 32'h1fff_03ff;
                        end
                    end
                end
            endcase
        end
    end

    // read mux
    always_comb begin
        rd_d  = 32'h0000_0000;
        rd_ok = mapped({araddr[7:2], 2'b00});
        case ({araddr[7:2], 2'b00})
            `DTT_OFF_CTRL:  rd_d = ctrl_q;
            `DTT_OFF_MODE:  rd_d = mode_q;
            `DTT_OFF_BLK:   rd_d = blk_q;
            `DTT_OFF_STAT:  rd_d = {18'h00000, trip_o, 2'b00, pickup_o};
            `DTT_OFF_IRQS:  rd_d = {18'h00000, irqs_q};
            `DTT_OFF_IRQM:  rd_d = irqm_q;
            `DTT_OFF_ROUTE: rd_d = route_q;
            default: begin
                for (int f = 0; f < `DTT_NUM_FUNC; f++) begin
                    if ({araddr[7:2], 2'b00} == `DTT_OFF_TDLY0 + 8'(4*f)) begin
                        rd_d = tdly_q[f];
                    end
                    if ({araddr[7:2], 2'b00} == `DTT_OFF_TIM0 + 8'(4*f)) begin
                        rd_d = tim_q[f];
                    end
                end
                for (int n = 0; n < `DTT_NUM_INST; n++) begin
                    if ({araddr[7:2], 2'b00} == `DTT_OFF_CNT0 + 8'(4*n)) begin
                        rd_d = cnt_q[n];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `DTT_RESP_OKAY;
        end else begin
            if (rd_take) begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= rd_d;
                rresp   <= rd_ok ? `DTT_RESP_OKAY : `DTT_RESP_SLVERR;
            end else begin
                if (rvalid && rready) begin
                    rvalid <= 1'b0;
                end
                if (!rvalid && !arready) begin
                    arready <= 1'b1;
                end
            end
        end
    end

    sequence s_write_done;
        aw_hold_q && w_hold_q && !bvalid;
    endsequence

    AST_BRESP_AFTER_BOTH: assert property (@(posedge aclk) disable iff (!aresetn)
        s_write_done |=> bvalid)
        else $error("write response missing after address and data");

    AST_RDATA_STABLE: assert property (@(posedge aclk) disable iff (!aresetn)
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped before rready");

    AST_IRQ_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 irq_o == |($past(irqs_q) & $past(irqm_q[13:0])))
        else $error("irq does not follow masked status");

    AST_EXT_CB_ROUTE: assert property (@(posedge aclk) disable iff (!aresetn) // R12
        tr_now[4] && route_q[0] |=> cb_trip_o)
        else $error("external trip not routed to breaker");

    AST_TRIP_CNT_RISE: assert property (@(posedge aclk) disable iff (!aresetn) // R11
        tr_now[4] && !trip_o[4] && !commit |=> cnt_q[4][31:16] == $past(cnt_q[4][31:16]) + 16'h0001)
        else $error("trip count did not step on rising trip");
endmodule

// ===== dv/discrete_input_trip_timer_test.sv
// self-checking bench of the discrete input trip timer
`timescale 1ns/100ps
module discrete_input_trip_timer_test;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [5:0]  close_req;
    logic [2:0]  user_var;
    logic        awready, wready, bvalid, arready, rvalid, cb_trip_o, led_o, irq_o;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [5:0]  pickup_o, trip_o, trip_in;
    logic [3:0]  relay_o;
    int          err_count, n_tests;

    dtt_top #(.TICK_CYCLES(10)) uut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .trip_in(trip_in), .user_var(user_var),
        .pickup_o(pickup_o), .trip_o(trip_o), .cb_trip_o(cb_trip_o), .relay_o(relay_o),
        .led_o(led_o), .irq_o(irq_o));
    dtt_contacts contacts (.close_req(close_req), .trip_in(trip_in));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                break;
            end
        end
        bready <= 1'b0;
        chk(32'(r), 32'h0);
        tick(1);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rexp);
        logic [31:0] d;
        logic [1:0]  r;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                break;
            end
        end
        rready <= 1'b0;
        chk(d, exp);
        chk(32'(r), 32'(rexp));
        tick(1);
    endtask
    task automatic t_reset;
        rchk(8'h00, 32'h0, 2'b00);
        rchk(8'h08, 32'h0064_0064, 2'b00);
        rchk(8'h14, 32'h0014_0005, 2'b00);
        rchk(8'h60, 32'h0, 2'b10);
    endtask
    task automatic t_off;
        close_req <= 6'h01;
        tick(80);
        chk(32'(pickup_o), 32'h0);
        close_req <= 6'h00;
        tick(5);
    endtask
    task automatic t_chain;
        axw(8'h00, 32'h7);
        axw(8'h04, 32'h7);
        axw(8'h08, 32'h1);
        axw(8'h14, 32'h0002_0005);
        axw(8'h2c, 32'h101);
        close_req <= 6'h01;
        tick(20);
        close_req <= 6'h00;
        tick(80);
        chk(32'(pickup_o), 32'h0);
        close_req <= 6'h01;
        tick(40);
        chk(32'(pickup_o), 32'h0);
        tick(30);
        chk(32'(pickup_o), 32'h01);
        chk(32'({irq_o, trip_o}), 32'h40);
        tick(110);
        chk(32'(trip_o), 32'h01);
        close_req <= 6'h00;
        tick(150);
        chk(32'({pickup_o, trip_o}), 32'h41);
        tick(70);
        chk(32'({pickup_o, trip_o}), 32'h0);
        rchk(8'h28, 32'h0000_0101, 2'b00);
        chk(32'(irq_o), 32'h0);
        rchk(8'h28, 32'h0, 2'b00);
        rchk(8'h40, 32'h0001_0001, 2'b00);
        axw(8'h40, 32'h0);
        rchk(8'h40, 32'h0, 2'b00);
    endtask
    task automatic t_block;
        axw(8'h18, 32'h0002_0005);
        axw(8'h20, 32'h14);
        user_var <= 3'h1;
        close_req <= 6'h0e;
        tick(80);
        chk(32'(pickup_o), 32'h08);
        user_var <= 3'h0;
        tick(80);
        chk(32'(pickup_o), 32'h0e);
        close_req <= 6'h00;
        tick(230);
    endtask
    task automatic t_route;
        axw(8'h10, 32'h0);
        axw(8'h1c, 32'h0002_0005);
        axw(8'h30, 32'h1b);
        close_req <= 6'h10;
        tick(80);
        chk(32'({pickup_o, trip_o}), 32'h410);
        chk(32'({cb_trip_o, led_o, relay_o}), 32'h34);
        close_req <= 6'h00;
        tick(230);
        chk(32'({cb_trip_o, led_o, relay_o, trip_o}), 32'h0);
        axw(8'h04, 32'h3);
        close_req <= 6'h20;
        tick(80);
        chk(32'(pickup_o), 32'h0);
        axw(8'h00, 32'h17);
        axw(8'h04, 32'h43);
        tick(80);
        chk(32'(pickup_o), 32'h20);
        close_req <= 6'h00;
    endtask
    task automatic wrap_up;
        $display("errors=%0d checks=%0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    initial begin
        tick(6000);
        err_count++;
        wrap_up;
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        close_req = 6'h00;
        user_var = 3'h0;
        err_count = 0;
        n_tests = 0;
        tick(3);
        aresetn <= 1'b1;
        tick(2);
        t_reset;
        t_off;
        t_chain;
        t_block;
        t_route;
        wrap_up;
    end
endmodule

// ===== dv/dtt_contacts.sv
// behavioural model of the external switch contacts on the trip inputs
`timescale 1ns/100ps
module dtt_contacts (
    // contact commands from the bench
    input  wire logic [5:0] close_req,
    // contact levels at the pins
    output logic      [5:0] trip_in
);
    initial trip_in = 6'h00;
    // contacts settle with no relation to the clock
    always @(close_req) trip_in <= #37 close_req;
endmodule
